/* rtl/lcd_ctrl_dev.sv */
// Display controller end of the host port
`include "lcd_port_cfg.svh"
`default_nettype none
// How it works
// - Selected write strobe latches bus byte
// - Selected read strobe drives a byte out
// - Strobes ignored unless chip enable low
// - Select picks command/data or status/data
// - Halt low freezes controller state unless port reset is low
// - Eight-bit bidirectional bus, bit 0 LSB
// - Display memory address spans 8K bytes
// - Character ROM holds 128 entries
// - Host polls status before data transfers
// - Bit 0 shows command acceptance
// - Bit 1 shows data transfer readiness
// - Host needs bits 0 and 1 together
// - Bits 2,3 show auto read/write ready
// - In auto mode only bits 2,3 valid
// - Bit 5 shows controller able to operate
// - Bit 6 flags peek or copy failure
// - Bit 7 follows blink phase
// - Host reads status before MSB-0 commands
// - Line-start MSB-0 command causes wait state
// - Host checks status while controller waits
// - Parameters first, then the command byte
// - Only last two parameter bytes kept
module lcd_ctrl_dev #(
   parameter int ADDR_W    = 13,
   parameter int ROM_DEPTH = `ROM_ENTRIES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Host port
   lcd_port_if.dev          port,
   // User side: executed commands
   output logic             cmd_valid,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_params,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [7:0]       wdata,
   output logic             wdata_valid,
   input  wire logic [7:0]  rdata,
   input  wire logic        peek_fail,
   output logic             blink_on
);
   // Two-stage synchronisers for all pins
   logic [5:0] pin_s1_q, pin_s2_q;
   logic [7:0] bus_s1_q, bus_s2_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 6'h3f;
         pin_s2_q <= 6'h3f;
         bus_s1_q <= 8'h00;
         bus_s2_q <= 8'h00;
      end else if (clk_en) begin
         pin_s1_q <= {port.wr_n, port.rd_n, port.ce_n, port.cmd_sel,
                      port.halt_n, port.reset_n};
         pin_s2_q <= pin_s1_q;
         bus_s1_q <= port.bus;
         bus_s2_q <= bus_s1_q;
      end
   end
   logic wr_n_s, rd_n_s, ce_n_s, sel_s, halt_n_s, rstp_n_s;
   assign {wr_n_s, rd_n_s, ce_n_s, sel_s, halt_n_s, rstp_n_s} = pin_s2_q;

   // Character pattern ROM, 128 entries by index
   // ROM contents
   logic [7:0] rom_q [ROM_DEPTH];
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < ROM_DEPTH; i++)
         rom_q[i] <= 8'(i);
   end

   // Controller state
   logic        wr_seen_q, wr_seen_d, rd_seen_q, rd_seen_d;
   logic [15:0] par_q, par_d;
   logic [7:0]  cmd_q, cmd_d;
   logic        cmd_pend_q, cmd_pend_d;
   logic        wait_q, wait_d;
   logic        auto_wr_q, auto_wr_d, auto_rd_q, auto_rd_d;
   logic        err_q, err_d;
   logic [15:0] line_cnt_q, line_cnt_d;
   logic [7:0]  blink_cnt_q, blink_cnt_d;
   logic        blink_q, blink_d;
   logic [3:0]  exec_q, exec_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [7:0]  dout_q, dout_d;
   logic        doe_q, doe_d;
   logic        cv_q, cv_d, wv_q, wv_d;
   logic [7:0]  wd_q, wd_d;
   logic        calc, busy;
   logic [7:0]  status;

   // Status word assembly
   always_comb begin
      calc = (line_cnt_q < `LINE_CALC_CYC);
      busy = (exec_q != 4'h0) || cmd_pend_q || wait_q;
      status = 8'h00;
      status[`STAT_CMD_READY_POS] = !busy && !auto_wr_q && !auto_rd_q;
      status[`STAT_DATA_READY_POS] = !busy && !calc && !auto_wr_q
                                     && !auto_rd_q;
      // auto readiness, valid only in auto mode
      status[`STAT_AUTO_READ_POS]  = auto_rd_q && !busy;
      status[`STAT_AUTO_WRITE_POS] = auto_wr_q && !busy;
      status[`STAT_UNUSED_POS]     = 1'b0;
      // able to operate while not halted
      status[`STAT_OP_READY_POS]   = halt_n_s;
      status[`STAT_ERROR_POS]      = err_q;
      status[`STAT_BLINK_POS]      = blink_q;
   end

   // Next-state logic of the controller
   always_comb begin
      logic wr_act, rd_act, wr_edge, rd_edge;
      wr_act = 1'b0;
      rd_act = 1'b0;
      wr_edge = 1'b0;
      rd_edge = 1'b0;
      wr_seen_d = wr_seen_q;
      rd_seen_d = rd_seen_q;
      par_d = par_q;
      cmd_d = cmd_q;
      cmd_pend_d = cmd_pend_q;
      wait_d = wait_q;
      auto_wr_d = auto_wr_q;
      auto_rd_d = auto_rd_q;
      err_d = err_q;
      line_cnt_d = line_cnt_q;
      blink_cnt_d = blink_cnt_q;
      blink_d = blink_q;
      exec_d = exec_q;
      addr_d = addr_q;
      dout_d = dout_q;
      doe_d = 1'b0;
      cv_d = 1'b0;
      wv_d = 1'b0;
      wd_d = wd_q;
      // strobes count only with chip enable low
      wr_act = !ce_n_s && !wr_n_s;
      rd_act = !ce_n_s && !rd_n_s;
      wr_edge = wr_act && !wr_seen_q;
      rd_edge = rd_act && !rd_seen_q;
      wr_seen_d = wr_act;
      rd_seen_d = rd_act;
      // Line timer with address calculation at each line start
      line_cnt_d = (line_cnt_q == `LINE_PERIOD_CYC - 16'h0001) ?
                   16'h0000 : line_cnt_q + 16'h0001;
      if (line_cnt_q == 16'h0000) begin
         blink_cnt_d = blink_cnt_q + 8'h01;
         if (blink_cnt_q == `BLINK_LINES - 8'h01) begin
            blink_cnt_d = 8'h00;
            blink_d = !blink_q;
         end
      end
      // wait state released once calculation is over
      if (wait_q && !calc)
         wait_d = 1'b0;
      if (exec_q != 4'h0)
         exec_d = exec_q - 4'h1;
      // drive status or data while read held
      if (rd_act) begin
         doe_d = 1'b1;
         if (rd_edge)
            dout_d = sel_s ? status : rdata;
      end
      if (wr_edge) begin
         // select high is command, low is data
         if (sel_s) begin
            cmd_d = bus_s2_q;
            cmd_pend_d = 1'b1;
            if (!bus_s2_q[`CMD_MSB_POS] && calc)
               wait_d = 1'b1;
         end else if (auto_wr_q) begin
            wd_d = bus_s2_q;
            wv_d = 1'b1;
            addr_d = addr_q + 1'b1;
         end else begin
            par_d = {bus_s2_q, par_q[15:8]};
         end
      end
      if (rd_edge && !sel_s && auto_rd_q)
         addr_d = addr_q + 1'b1;
      if (cmd_pend_q && !wait_q && exec_q == 4'h0) begin
         // A command byte landing in this very cycle stays pending
         if (!(wr_edge && sel_s))
            cmd_pend_d = 1'b0;
         exec_d = `EXEC_CYC;
         cv_d = 1'b1;
         unique case (cmd_q)
            `CMD_AUTO_WRITE: auto_wr_d = 1'b1;
            `CMD_AUTO_READ:  auto_rd_d = 1'b1;
            `CMD_AUTO_RESET: begin
               auto_wr_d = 1'b0;
               auto_rd_d = 1'b0;
            end
            `CMD_PEEK, `CMD_COPY: err_d = peek_fail;
            8'h24: addr_d = par_q[ADDR_W-1:0];
            default: ;
         endcase
      end
   end

   // State registers; halt and the port reset act as freezes/clears
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_seen_q <= 1'b0;  rd_seen_q <= 1'b0;
         par_q <= 16'h0000;  cmd_q <= 8'h00;  cmd_pend_q <= 1'b0;
         wait_q <= 1'b0;  auto_wr_q <= 1'b0;  auto_rd_q <= 1'b0;
         err_q <= 1'b0;  line_cnt_q <= 16'h0000;
         blink_cnt_q <= 8'h00;  blink_q <= 1'b1;  exec_q <= 4'h0;
         addr_q <= '0;  dout_q <= 8'h00;  doe_q <= 1'b0;
         cv_q <= 1'b0;  wv_q <= 1'b0;  wd_q <= 8'h00;
      // port reset abandons command and parameters
      end else if (clk_en && !rstp_n_s) begin
         wr_seen_q <= 1'b0;  rd_seen_q <= 1'b0;
         par_q <= 16'h0000;  cmd_q <= 8'h00;  cmd_pend_q <= 1'b0;
         wait_q <= 1'b0;  auto_wr_q <= 1'b0;  auto_rd_q <= 1'b0;
         err_q <= 1'b0;  line_cnt_q <= 16'h0000;
         blink_cnt_q <= 8'h00;  blink_q <= 1'b1;  exec_q <= 4'h0;
         addr_q <= '0;  dout_q <= 8'h00;  doe_q <= 1'b0;
         cv_q <= 1'b0;  wv_q <= 1'b0;  wd_q <= 8'h00;
      // halt low stops the internal clock
      end else if (clk_en && halt_n_s) begin
         wr_seen_q <= wr_seen_d;  rd_seen_q <= rd_seen_d;
         par_q <= par_d;  cmd_q <= cmd_d;  cmd_pend_q <= cmd_pend_d;
         wait_q <= wait_d;  auto_wr_q <= auto_wr_d;
         auto_rd_q <= auto_rd_d;  err_q <= err_d;
         line_cnt_q <= line_cnt_d;  blink_cnt_q <= blink_cnt_d;
         blink_q <= blink_d;  exec_q <= exec_d;
         addr_q <= addr_d;
         dout_q <= dout_d;  doe_q <= doe_d;
         cv_q <= cv_d;  wv_q <= wv_d;  wd_q <= wd_d;
      end
   end

   // Outputs straight from flops
   assign port.bus_dev_o  = dout_q;
   assign port.bus_dev_oe = doe_q;
   assign cmd_valid   = cv_q;
   assign cmd_code    = cmd_q;
   assign cmd_params  = par_q;
   assign mem_addr    = addr_q;
   assign wdata       = wd_q;
   assign wdata_valid = wv_q;
   assign blink_on    = blink_q;
endmodule
`default_nettype wire

/* rtl/lcd_host_end.sv */
// Microprocessor end of the LCD controller host port
`include "lcd_port_cfg.svh"
`default_nettype none
module lcd_host_end (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Host port
   lcd_port_if.host         port,
   // User request
   input  wire logic        req_valid,
   input  wire lcd_port_pkg::host_op_e req_op,
   input  wire logic [7:0]  req_data,
   input  wire logic        auto_mode,
   input  wire logic        halt_req,
   input  wire logic        port_reset,
   output logic             req_ready,
   output logic             resp_valid,
   output logic [7:0]       resp_data
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_POLL = 3'b001, ST_PCHK = 3'b011,
      ST_XFER = 3'b010, ST_DONE = 3'b110
   } st_e;
   logic [7:0] bus_s1_q, bus_s2_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bus_s1_q <= 8'h00;
         bus_s2_q <= 8'h00;
      end else if (clk_en) begin
         bus_s1_q <= port.bus;
         bus_s2_q <= bus_s1_q;
      end
   end
   st_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   lcd_port_pkg::host_op_e op_q, op_d;
   logic [7:0] dat_q, dat_d, rsp_q, rsp_d;
   logic rv_q, rv_d, wr_q, wr_d, rd_q, rd_d, ce_q, ce_d, sel_q, sel_d;
   logic oe_q, oe_d;
   // Sequencer: every transfer is preceded by a status poll
   always_comb begin
      st_d = st_q;  cnt_d = cnt_q;  op_d = op_q;  dat_d = dat_q;
      rsp_d = rsp_q;  rv_d = 1'b0;  wr_d = 1'b1;  rd_d = 1'b1;
      ce_d = 1'b1;  sel_d = sel_q;  oe_d = 1'b0;
      unique case (st_q)
         ST_IDLE: if (req_valid) begin
            op_d = req_op;
            dat_d = req_data;
            st_d = ST_POLL;
            cnt_d = `HOST_STROBE_CYC + 4'h2;
         end
         ST_POLL: begin
            ce_d = 1'b0;  rd_d = 1'b0;  sel_d = 1'b1;
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
               rd_d = 1'b1;
               st_d = ST_PCHK;
            end
         end
         ST_PCHK: begin
            // check the right pair in one sample
            if (op_q == lcd_port_pkg::HOST_OP_STATUS) begin
               rsp_d = bus_s2_q;  rv_d = 1'b1;  st_d = ST_DONE;
            end else if (auto_mode ? (bus_s2_q[`STAT_AUTO_READ_POS] ||
                                      bus_s2_q[`STAT_AUTO_WRITE_POS])
                         : (bus_s2_q[`STAT_CMD_READY_POS] &&
                            bus_s2_q[`STAT_DATA_READY_POS])) begin
               st_d = ST_XFER;
               cnt_d = `HOST_STROBE_CYC + 4'h2;
            end else begin
               st_d = ST_POLL;
               cnt_d = `HOST_STROBE_CYC + 4'h2;
            end
         end
         ST_XFER: begin
            ce_d = 1'b0;
            sel_d = (op_q == lcd_port_pkg::HOST_OP_CMD);
            // data bytes sent before command byte by caller
            if (op_q == lcd_port_pkg::HOST_OP_RDATA) rd_d = 1'b0;
            else begin
               // Strobe falls a cycle after the bus turns, so the
               // controller never samples its own status byte
               wr_d = (cnt_q == `HOST_STROBE_CYC + 4'h2);
               oe_d = 1'b1;
            end
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
               wr_d = 1'b1;  rd_d = 1'b1;
               st_d = ST_DONE;
            end
         end
         // Read byte reaches the bus synchroniser one cycle later
         ST_DONE: begin
            if (op_q == lcd_port_pkg::HOST_OP_RDATA) begin
               rsp_d = bus_s2_q;
               rv_d = 1'b1;
            end
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;  cnt_q <= 4'h0;
         op_q <= lcd_port_pkg::HOST_OP_STATUS;  dat_q <= 8'h00;
         rsp_q <= 8'h00;  rv_q <= 1'b0;  wr_q <= 1'b1;  rd_q <= 1'b1;
         ce_q <= 1'b1;  sel_q <= 1'b0;  oe_q <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;  cnt_q <= cnt_d;  op_q <= op_d;  dat_q <= dat_d;
         rsp_q <= rsp_d;  rv_q <= rv_d;  wr_q <= wr_d;  rd_q <= rd_d;
         ce_q <= ce_d;  sel_q <= sel_d;  oe_q <= oe_d;
      end
   end
   // Pin controls that only mirror user levels, registered
   logic halt_q, prst_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         halt_q <= 1'b0;
         prst_q <= 1'b0;
      end else if (clk_en) begin
         halt_q <= halt_req;
         prst_q <= port_reset;
      end
   end
   assign port.wr_n = wr_q;
   assign port.rd_n = rd_q;
   assign port.ce_n = ce_q;
   assign port.cmd_sel = sel_q;
   assign port.halt_n = !halt_q;
   assign port.reset_n = !prst_q;
   assign port.bus_host_o = dat_q;
   assign port.bus_host_oe = oe_q;
   assign req_ready = (st_q == ST_IDLE);
   assign resp_valid = rv_q;
   assign resp_data = rsp_q;
endmodule
`default_nettype wire

/* rtl/lcd_port_cfg.svh */
// Constants for the LCD controller host port
`ifndef LCD_PORT_CFG_SVH
`define LCD_PORT_CFG_SVH
`define STAT_CMD_READY_POS        0
`define STAT_DATA_READY_POS       1
`define STAT_AUTO_READ_POS        2
`define STAT_AUTO_WRITE_POS       3
`define STAT_UNUSED_POS           4
`define STAT_OP_READY_POS         5
`define STAT_ERROR_POS            6
`define STAT_BLINK_POS            7
`define CMD_MSB_POS               7
`define CMD_AUTO_WRITE            8'hb0
`define CMD_AUTO_READ             8'hb1
`define CMD_AUTO_RESET            8'hb2
`define CMD_PEEK                  8'he0
`define CMD_COPY                  8'he8
`define CMD_DATA_RW_HI            5'h18
`define LINE_PERIOD_CYC           16'h0100
`define LINE_CALC_CYC             16'h0008
`define BLINK_LINES               8'h40
`define EXEC_CYC                  4'h4
`define HOST_STROBE_CYC           4'h3
`define MEM_BYTES                 8192
`define ROM_ENTRIES               128
`endif

/* rtl/lcd_port_if.sv */
// Parallel bus between host and display controller
`default_nettype none
interface lcd_port_if;
   logic       wr_n;
   logic       rd_n;
   logic       ce_n;
   logic       cmd_sel;
   logic       halt_n;
   logic       reset_n;
   logic [7:0] bus_host_o;
   logic       bus_host_oe;
   logic [7:0] bus_dev_o;
   logic       bus_dev_oe;
   logic [7:0] bus;
   // Wire level resolved from the two enables
   assign bus = bus_dev_oe ? bus_dev_o :
                (bus_host_oe ? bus_host_o : 8'hff);
   modport dev (input wr_n, rd_n, ce_n, cmd_sel, halt_n, reset_n,
                input bus, output bus_dev_o, bus_dev_oe);
   modport host (output wr_n, rd_n, ce_n, cmd_sel, halt_n, reset_n,
                 input bus, output bus_host_o, bus_host_oe);
endinterface
`default_nettype wire

/* rtl/lcd_port_pkg.sv */
// Types used by the host end of the LCD controller host port
`default_nettype none
package lcd_port_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      HOST_OP_STATUS = 2'h0,
      HOST_OP_CMD    = 2'h1,
      HOST_OP_WDATA  = 2'h2,
      HOST_OP_RDATA  = 2'h3
   } host_op_e;
endpackage
`default_nettype wire

/* test/lcd_controller_host_port_tb.sv */
// Testbench joining host end and controller end of the port
`default_nettype none
module lcd_controller_host_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      lcd_port_pkg::host_op_e op;
      logic [7:0]             d;
      logic [15:0]            exp;
   } row_s;
   logic                   sys_clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   req_valid = 1'b0;
   lcd_port_pkg::host_op_e req_op = lcd_port_pkg::HOST_OP_STATUS;
   logic [7:0]             req_data = 8'h00;
   logic                   auto_mode = 1'b0;
   logic                   halt_req = 1'b0;
   logic                   port_reset = 1'b0;
   logic [7:0]             rdata = 8'ha5;
   logic                   peek_fail = 1'b0;
   logic                   req_ready, resp_valid, cmd_valid;
   logic                   wdata_valid, blink_on;
   logic [7:0]             resp_data, cmd_code, wdata;
   logic [7:0]             got_resp, got_code, got_wdata;
   logic [15:0]            cmd_params, got_par;
   logic [12:0]            mem_addr;
   int                     checks = 0;
   int                     bad_count = 0;
   int                     cv_count = 0;
   row_s rows[9] = '{
      // First poll falls in the line-start calculation window
      '{lcd_port_pkg::HOST_OP_STATUS, 8'h00, 16'h0021},
      '{lcd_port_pkg::HOST_OP_WDATA,  8'h34, 16'h0000},
      '{lcd_port_pkg::HOST_OP_WDATA,  8'h12, 16'h0000},
      '{lcd_port_pkg::HOST_OP_CMD,    8'h24, 16'h1234},
      '{lcd_port_pkg::HOST_OP_WDATA,  8'h11, 16'h0000},
      '{lcd_port_pkg::HOST_OP_WDATA,  8'h22, 16'h0000},
      '{lcd_port_pkg::HOST_OP_WDATA,  8'h33, 16'h0000},
      '{lcd_port_pkg::HOST_OP_CMD,    8'h24, 16'h3322},
      '{lcd_port_pkg::HOST_OP_RDATA,  8'h00, 16'h00a5}};
   lcd_port_if u_lcd_port_if ();
   lcd_ctrl_dev u_lcd_ctrl_dev (
      .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .port(u_lcd_port_if),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_params(cmd_params),
      .mem_addr(mem_addr), .wdata(wdata), .wdata_valid(wdata_valid),
      .rdata(rdata), .peek_fail(peek_fail), .blink_on(blink_on));
   lcd_host_end u_lcd_host_end (
      .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .port(u_lcd_port_if),
      .req_valid(req_valid), .req_op(req_op), .req_data(req_data),
      .auto_mode(auto_mode), .halt_req(halt_req),
      .port_reset(port_reset), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data));
   lcd_port_monitor u_lcd_port_monitor (
      .sys_clk(sys_clk), .rst(rst), .wr_n(u_lcd_port_if.wr_n),
      .rd_n(u_lcd_port_if.rd_n), .ce_n(u_lcd_port_if.ce_n),
      .cmd_sel(u_lcd_port_if.cmd_sel), .halt_n(u_lcd_port_if.halt_n),
      .reset_n(u_lcd_port_if.reset_n),
      .bus_host_o(u_lcd_port_if.bus_host_o),
      .bus_dev_oe(u_lcd_port_if.bus_dev_oe));
   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;
   // Latch pulsed outputs at the falling edge, where they are settled
   always @(negedge sys_clk) begin
      if (cmd_valid) begin
         cv_count++;
         got_code = cmd_code;
         got_par = cmd_params;
      end
      if (resp_valid) got_resp = resp_data;
      if (wdata_valid) got_wdata = wdata;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One user request; bounded wait so a stuck host shows as a mismatch
   task automatic do_op(input lcd_port_pkg::host_op_e op,
                        input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      req_op = op;
      req_data = d;
      req_valid = 1'b1;
      @(negedge sys_clk);
      req_valid = 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 400) check(16'hdead, 16'h0000);
      // Covers the execute busy time after the host goes idle
      repeat (10) @(negedge sys_clk);
   endtask
   // Watchdog sized well above the expected run length
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      int c;
      logic b;
      repeat (20) @(negedge sys_clk);
      check(16'(u_lcd_port_if.bus_dev_oe), 16'h0000);
      check(16'({blink_on, req_ready, u_lcd_port_if.ce_n}), 16'h0007);
      rst = 1'b0;
      foreach (rows[i]) begin
         do_op(rows[i].op, rows[i].d);
         if (rows[i].op == lcd_port_pkg::HOST_OP_STATUS) begin
            check(16'(got_resp & 8'h73), rows[i].exp);
         end else if (rows[i].op == lcd_port_pkg::HOST_OP_CMD) begin
            check(16'(got_code), 16'(rows[i].d));
            check(got_par, rows[i].exp);
            check(16'(mem_addr), 16'(rows[i].exp[12:0]));
         end else if (rows[i].op == lcd_port_pkg::HOST_OP_RDATA) begin
            check(16'(got_resp), rows[i].exp);
         end
      end
      do_op(lcd_port_pkg::HOST_OP_STATUS, 8'h00);
      check(16'(got_resp[7]), 16'h0001);
      // Peek failure sets the error bit, a clean copy clears it
      peek_fail = 1'b1;
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'he0);
      do_op(lcd_port_pkg::HOST_OP_STATUS, 8'h00);
      check(16'(got_resp[6]), 16'h0001);
      peek_fail = 1'b0;
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'he8);
      do_op(lcd_port_pkg::HOST_OP_STATUS, 8'h00);
      check(16'(got_resp[6]), 16'h0000);
      // Auto write: only bits 2 and 3 count until auto reset
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'hb0);
      auto_mode = 1'b1;
      do_op(lcd_port_pkg::HOST_OP_STATUS, 8'h00);
      check(16'(got_resp[3]), 16'h0001);
      do_op(lcd_port_pkg::HOST_OP_WDATA, 8'h5a);
      check(16'(got_wdata), 16'h005a);
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'hb2);
      auto_mode = 1'b0;
      // Port reset drops the stale parameter byte
      do_op(lcd_port_pkg::HOST_OP_WDATA, 8'h77);
      port_reset = 1'b1;
      repeat (8) @(negedge sys_clk);
      port_reset = 1'b0;
      repeat (8) @(negedge sys_clk);
      do_op(lcd_port_pkg::HOST_OP_WDATA, 8'hab);
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'h24);
      check(got_par, 16'hab00);
      // Halt freezes the controller, release resumes it
      halt_req = 1'b1;
      repeat (10) @(negedge sys_clk);
      c = cv_count;
      b = blink_on;
      // Frozen controller leaves the pull-up level, which reads as
      // ready, so the host sends a command that must not execute
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'h24);
      check(16'(cv_count - c), 16'h0000);
      check(16'(blink_on), 16'(b));
      halt_req = 1'b0;
      repeat (10) @(negedge sys_clk);
      do_op(lcd_port_pkg::HOST_OP_CMD, 8'h24);
      check(16'(cv_count - c), 16'h0001);
      check(got_par, 16'hab00);
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* test/lcd_port_monitor.sv */
// Concurrent checks on the wires between host and display controller
`default_nettype none
module lcd_port_monitor (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // Port wires
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic       ce_n,
   input wire logic       cmd_sel,
   input wire logic       halt_n,
   input wire logic       reset_n,
   input wire logic [7:0] bus_host_o,
   input wire logic       bus_dev_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic stat_rd;
   logic xfer;
   logic xfer_d;
   logic xfer_q;
   logic poll_d;
   logic poll_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Decode of the status poll and of any other transfer
   assign stat_rd = !ce_n && !rd_n && cmd_sel;
   assign xfer    = !ce_n && (!wr_n || (!rd_n && !cmd_sel));
   // Poll credit is spent when a transfer ends, so each one needs its own
   always_comb begin
      xfer_d = xfer;
      poll_d = poll_q;
      if (stat_rd) begin
         poll_d = 1'b1;
      end else if (xfer_q && !xfer) begin
         poll_d = 1'b0;
      end
   end
   // Poll tracking registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         xfer_q <= 1'b0;
         poll_q <= 1'b0;
      end else begin
         xfer_q <= xfer_d;
         poll_q <= poll_d;
      end
   end
   read_drive_a: assert property (
      (!rd_n && !ce_n && halt_n && reset_n)[*5] |-> bus_dev_oe)
      else $error("read strobe held but controller not driving");
   idle_release_a: assert property (
      (ce_n && halt_n)[*6] |-> !bus_dev_oe)
      else $error("controller drives bus while deselected");
   strobe_excl_a: assert property (
      !wr_n |-> rd_n)
      else $error("write and read strobes low together");
   wdata_hold_a: assert property (
      !wr_n && !ce_n && $past(!wr_n && !ce_n) |-> $stable(bus_host_o))
      else $error("write byte changed during strobe");
   poll_first_a: assert property (
      xfer |-> poll_q)
      else $error("transfer without a status poll first");
   reset_release_a: assert property (
      (!reset_n)[*4] |-> !bus_dev_oe)
      else $error("controller drives bus during port reset");
   halt_freeze_a: assert property (
      (!halt_n)[*4] |=> $stable(bus_dev_oe))
      else $error("controller bus enable moved while halted");
   sel_hold_a: assert property (
      !ce_n && $past(!ce_n) |-> $stable(cmd_sel))
      else $error("select line changed while chip enabled");
   // Main traffic kinds and a sustained halt
   cover property (stat_rd ##1 !stat_rd);
   cover property (!wr_n && !ce_n && cmd_sel);
   cover property (!wr_n && !ce_n && !cmd_sel);
   cover property ((!halt_n)[*4]);
endmodule
`default_nettype wire
